// ---- rtl/dir_pkg.sv ----
// package: constants for the distributed interrupt routing block
package dir_pkg;

  localparam int unsigned DIR_LINES = 12;
  localparam int unsigned DIR_PINS = 12;
  localparam int unsigned DIR_TIMERS = 8;
  localparam int unsigned DIR_CNT_W = 32;

  // --------------------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------------------
  localparam logic [11:0] DIR_OFF_SRC0 = 12'h000;    // 12 words, one per line
  localparam logic [11:0] DIR_OFF_TRIG = 12'h040;
  localparam logic [11:0] DIR_OFF_ARM_SET = 12'h044;
  localparam logic [11:0] DIR_OFF_ARM_CLR = 12'h048;
  localparam logic [11:0] DIR_OFF_EN_SET = 12'h04c;
  localparam logic [11:0] DIR_OFF_EN_CLR = 12'h050;
  localparam logic [11:0] DIR_OFF_KEEP = 12'h054;
  localparam logic [11:0] DIR_OFF_RELEASE = 12'h058;
  localparam logic [11:0] DIR_OFF_REQUEST = 12'h05c;
  localparam logic [11:0] DIR_OFF_STATUS = 12'h060;
  localparam logic [11:0] DIR_OFF_PIN_DIR = 12'h064;
  localparam logic [11:0] DIR_OFF_PIN_TERM = 12'h068;
  localparam logic [11:0] DIR_OFF_CLKCFG = 12'h06c;
  localparam logic [11:0] DIR_OFF_PIN_OUT0 = 12'h070;   // 12 words
  localparam logic [11:0] DIR_OFF_ERROR = 12'h0a0;
  localparam logic [11:0] DIR_OFF_PIG = 12'h0a4;
  localparam logic [11:0] DIR_OFF_PIG_SET = 12'h0a8;
  localparam logic [11:0] DIR_OFF_PIG_CLR = 12'h0ac;
  localparam logic [11:0] DIR_OFF_CNT0 = 12'h100;    // 12 words

  // source selector encoding: kind in [6:4], index in [3:0]
  localparam logic [2:0] DIR_SK_NONE = 3'h0;
  localparam logic [2:0] DIR_SK_TIMER = 3'h1;
  localparam logic [2:0] DIR_SK_PIG = 3'h2;
  localparam logic [2:0] DIR_SK_INPUT = 3'h3;
  localparam logic [2:0] DIR_SK_GPS = 3'h4;
  localparam logic [2:0] DIR_SK_IRIG = 3'h5;
  localparam logic [2:0] DIR_SK_DI = 3'h6;     // pin outputs only
  localparam logic [6:0] DIR_SRC_RST = 7'h00;

  // trigger modes, two bits per line
  localparam logic [1:0] DIR_TM_RISE = 2'h0;
  localparam logic [1:0] DIR_TM_FALL = 2'h1;
  localparam logic [1:0] DIR_TM_HIGH = 2'h2;
  localparam logic [1:0] DIR_TM_LOW = 2'h3;

  localparam logic [11:0] DIR_PIN_DIR_RST = 12'h03f;   // 1 = output
  localparam logic [11:0] DIR_PIN_TERM_RST = 12'h000;

  // clkcfg bits
  localparam int unsigned DIR_CC_EXTREF = 0;
  localparam int unsigned DIR_CC_MASTER = 1;
  localparam int unsigned DIR_CC_SLAVE = 2;
  localparam int unsigned DIR_CC_GPS = 3;
  localparam int unsigned DIR_CC_PIN_LSB = 4;
  localparam logic [7:0] DIR_CLKCFG_RST = 8'h02;

  localparam int unsigned DIR_CLK_HZ = 25000000;
  localparam int unsigned DIR_XTAL_HZ = 10000000;
  localparam int unsigned DIR_TICK_NUM = DIR_XTAL_HZ / 100000;  // phase step per pclk
  localparam int unsigned DIR_TICK_DEN = DIR_CLK_HZ / 100000;
  localparam logic [31:0] DIR_ERR_INVAL = 32'h0000_0016;

endpackage

// ---- rtl/dir_line_detect.sv ----
// one distributed interrupt line: synchroniser, trigger detect, fire counter
`timescale 1ns/100ps
module dir_line_detect
  import dir_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic line_in,
  input wire logic [1:0] trig_mode,
  input wire logic armed,
  input wire logic enabled,
  input wire logic sw_request,
  output logic fire,
  output logic [DIR_CNT_W-1:0] fire_count
);

  logic sync1_ff, sync2_ff, prev_ff, lvl_hold_ff;
  logic hit;
  logic [DIR_CNT_W-1:0] cnt_ff;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      sync1_ff <= line_in;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // level modes fire once per entry into the active level, not every cycle
  always_comb begin
    case (trig_mode)
      DIR_TM_RISE: hit = sync2_ff & ~prev_ff;
      DIR_TM_FALL: hit = ~sync2_ff & prev_ff;
      DIR_TM_HIGH: hit = sync2_ff & ~lvl_hold_ff;
      DIR_TM_LOW: hit = ~sync2_ff & ~lvl_hold_ff;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_hold_ff <= 1'b0;
    end else begin
      lvl_hold_ff <= (trig_mode == DIR_TM_HIGH) ? sync2_ff : (trig_mode == DIR_TM_LOW) ? ~sync2_ff : 1'b0;
    end
  end

  assign fire = (hit | sw_request) & armed & enabled;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else if (fire) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign fire_count = cnt_ff;

endmodule

// ---- rtl/dir_tick_gen.sv ----
// time base: tick enable from crystal phase or external 10 MHz reference
`timescale 1ns/100ps
module dir_tick_gen
  import dir_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic use_ext,
  input wire logic ext_ref,
  output logic tick,
  output logic [31:0] time_count
);

  logic s1_ff, s2_ff, s3_ff;
  logic [7:0] acc_ff;
  logic int_tick;
  logic [8:0] acc_sum;
  logic [31:0] time_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= ext_ref;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // fractional accumulator models the 10 MHz crystal from the 25 MHz bus clock
  assign acc_sum = {1'b0, acc_ff} + 9'(DIR_TICK_NUM);
  assign int_tick = acc_sum >= 9'(DIR_TICK_DEN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= '0;
    end else begin
      acc_ff <= int_tick ? 8'(acc_sum - 9'(DIR_TICK_DEN)) : acc_sum[7:0];
    end
  end

  assign tick = use_ext ? (s2_ff & ~s3_ff) : int_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_ff <= '0;
    end else if (tick) begin
      time_ff <= time_ff + 1'b1;
    end
  end

  assign time_count = time_ff;

endmodule

// ---- rtl/dir_top.sv ----
// top: APB register file, source routing, pin setup and line instances
//
// Functional notes
// - any timer, input, GPS pulse or pulse generator may drive a line.
// - after reset no line has a source, so none is driven.
// - per-line source selector: timer, generator, input, GPS, IRIG or none.
// - each line triggers on rising, falling, high or low.
// - delivery needs both arm and enable, each with separate controls.
// - releasing the last user disarms unless keep-armed-on-close is set.
// - software may request an interrupt on a line directly.
// - each line keeps a readable fire count.
// - external 10 MHz reference replaces the crystal when selected.
// - reference comes from a pin assigned to it, which must be input.
// - each pin has direction and termination settings.
// - reset makes pins 0-5 outputs, 6-11 inputs, none terminated.
// - pins act as sources only as inputs, driven only as outputs.
// - routing a pin's own input to its output is refused as invalid.
// - time-master role on by default, software may turn it off.
// - a chain slave drops the time-master role and refuses the GPS source.
// - twelve lines, 0 to 11, reach all chained systems.
`timescale 1ns/100ps
module dir_top
  import dir_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [DIR_TIMERS-1:0] timer_pulse,
  input wire logic gps_pps,
  input wire logic irig_pps,
  input wire logic [DIR_LINES-1:0] distributed_interrupt_line_in,
  output logic [DIR_LINES-1:0] distributed_interrupt_line_out,
  output logic [DIR_LINES-1:0] distributed_interrupt_line_oe,
  input wire logic [DIR_PINS-1:0] pin_in,
  output logic [DIR_PINS-1:0] pin_out,
  output logic [DIR_PINS-1:0] pin_oe,
  output logic [DIR_PINS-1:0] pin_term,
  output logic [DIR_LINES-1:0] irq_fire,
  output logic time_master,
  output logic time_tick
);

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [6:0] src_ff [DIR_LINES];
  logic [6:0] pin_src_ff [DIR_PINS];
  logic [2*DIR_LINES-1:0] trig_ff;
  logic [DIR_LINES-1:0] arm_ff, en_ff, keep_ff, req_ff, status_ff;
  logic [DIR_PINS-1:0] dir_ff, term_ff, pig_ff;
  logic [7:0] clkcfg_ff;
  logic [31:0] err_ff;
  logic [31:0] prdata_ff, nxt_prdata;
  logic wr, rd, mapped;
  logic [3:0] widx;
  logic [DIR_LINES-1:0] fire;
  logic [DIR_CNT_W-1:0] cnt [DIR_LINES];
  logic [DIR_PINS-1:0] pin_rx;
  logic [31:0] time_count;
  logic ext_ref, gps_ok, req_invalid;

  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign widx = paddr[5:2];

  always_comb begin
    mapped = 1'b0;
    if (paddr[1:0] == 2'h0) begin
      if (paddr < DIR_OFF_SRC0 + 12'(4 * DIR_LINES)) mapped = 1'b1;
      else if (paddr >= DIR_OFF_TRIG && paddr <= DIR_OFF_CLKCFG) mapped = 1'b1;
      else if (paddr >= DIR_OFF_PIN_OUT0 && paddr < DIR_OFF_PIN_OUT0 + 12'(4 * DIR_PINS)) mapped = 1'b1;
      else if (paddr >= DIR_OFF_ERROR && paddr <= DIR_OFF_PIG_CLR) mapped = 1'b1;
      else if (paddr >= DIR_OFF_CNT0 && paddr < DIR_OFF_CNT0 + 12'(4 * DIR_LINES)) mapped = 1'b1;
    end
  end

  // a refused routing write is still a completed transfer, flagged by pslverr
  assign req_invalid = wr && paddr >= DIR_OFF_PIN_OUT0 && paddr < DIR_OFF_PIN_OUT0 + 12'(4 * DIR_PINS)
    && pwdata[6:4] == DIR_SK_INPUT && pwdata[3:0] == 4'(paddr[5:2] - DIR_OFF_PIN_OUT0[5:2]);
  assign pslverr = psel & penable & (~mapped | req_invalid);

  // --------------------------------------------------------------------------
  // line configuration
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DIR_LINES; i++) src_ff[i] <= DIR_SRC_RST;
    end else if (wr && paddr < DIR_OFF_SRC0 + 12'(4 * DIR_LINES)) begin
      src_ff[widx] <= pwdata[6:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_ff <= '0;
    end else if (wr && paddr == DIR_OFF_TRIG) begin
      trig_ff <= pwdata[2*DIR_LINES-1:0];
    end
  end

  // release disarms lines whose keep bit is clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_ff <= '0;
    end else if (wr && paddr == DIR_OFF_ARM_SET) begin
      arm_ff <= arm_ff | pwdata[DIR_LINES-1:0];
    end else if (wr && paddr == DIR_OFF_ARM_CLR) begin
      arm_ff <= arm_ff & ~pwdata[DIR_LINES-1:0];
    end else if (wr && paddr == DIR_OFF_RELEASE) begin
      arm_ff <= arm_ff & ~(pwdata[DIR_LINES-1:0] & ~keep_ff);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= '0;
    end else if (wr && paddr == DIR_OFF_EN_SET) begin
      en_ff <= en_ff | pwdata[DIR_LINES-1:0];
    end else if (wr && paddr == DIR_OFF_EN_CLR) begin
      en_ff <= en_ff & ~pwdata[DIR_LINES-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keep_ff <= '0;
    end else if (wr && paddr == DIR_OFF_KEEP) begin
      keep_ff <= pwdata[DIR_LINES-1:0];
    end
  end

  // software request is a one-cycle pulse into the detectors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff <= '0;
    end else begin
      req_ff <= (wr && paddr == DIR_OFF_REQUEST) ? pwdata[DIR_LINES-1:0] : '0;
    end
  end

  // status: sticky fired flags, write one to clear, a new fire wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= '0;
    end else if (wr && paddr == DIR_OFF_STATUS) begin
      status_ff <= (status_ff & ~pwdata[DIR_LINES-1:0]) | fire;
    end else begin
      status_ff <= status_ff | fire;
    end
  end

  // --------------------------------------------------------------------------
  // pins, generators, clocking
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_ff <= DIR_PIN_DIR_RST;
      term_ff <= DIR_PIN_TERM_RST;
    end else begin
      if (wr && paddr == DIR_OFF_PIN_DIR) dir_ff <= pwdata[DIR_PINS-1:0];
      if (wr && paddr == DIR_OFF_PIN_TERM) term_ff <= pwdata[DIR_PINS-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DIR_PINS; i++) pin_src_ff[i] <= DIR_SRC_RST;
    end else if (wr && !req_invalid && paddr >= DIR_OFF_PIN_OUT0 && paddr < DIR_OFF_PIN_OUT0 + 12'(4 * DIR_PINS)) begin
      pin_src_ff[4'(paddr[5:2] - DIR_OFF_PIN_OUT0[5:2])] <= pwdata[6:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_ff <= '0;
    end else if (req_invalid) begin
      err_ff <= DIR_ERR_INVAL;
    end else if (wr && paddr == DIR_OFF_ERROR) begin
      err_ff <= '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pig_ff <= '0;
    end else if (wr && paddr == DIR_OFF_PIG) begin
      pig_ff <= pwdata[DIR_PINS-1:0];
    end else if (wr && paddr == DIR_OFF_PIG_SET) begin
      pig_ff <= pig_ff | pwdata[DIR_PINS-1:0];
    end else if (wr && paddr == DIR_OFF_PIG_CLR) begin
      pig_ff <= pig_ff & ~pwdata[DIR_PINS-1:0];
    end
  end

  // slave bit forces gps acceptance off; master bit defaults on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clkcfg_ff <= DIR_CLKCFG_RST;
    end else if (wr && paddr == DIR_OFF_CLKCFG) begin
      clkcfg_ff <= pwdata[7:0];
    end
  end

  assign time_master = clkcfg_ff[DIR_CC_MASTER] & ~clkcfg_ff[DIR_CC_SLAVE];
  assign gps_ok = clkcfg_ff[DIR_CC_GPS] & ~clkcfg_ff[DIR_CC_SLAVE];
  assign pin_rx = pin_in & ~dir_ff;

  // reference only honoured while the assigned pin is an input
  assign ext_ref = pin_rx[clkcfg_ff[DIR_CC_PIN_LSB +: 4]];

  dir_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .use_ext(clkcfg_ff[DIR_CC_EXTREF]),
    .ext_ref(ext_ref),
    .tick(time_tick),
    .time_count(time_count)
  );

  function automatic logic pick(input logic [6:0] sel);
    logic v;
    v = 1'b0;
    case (sel[6:4])
      DIR_SK_TIMER: v = timer_pulse[sel[2:0]];
      DIR_SK_PIG: v = pig_ff[sel[3:0]];
      DIR_SK_INPUT: v = pin_rx[sel[3:0]];
      DIR_SK_GPS: v = gps_pps & gps_ok;
      DIR_SK_IRIG: v = irig_pps;
      DIR_SK_DI: v = distributed_interrupt_line_in[sel[3:0]];
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // --------------------------------------------------------------------------
  // outputs and per-line detectors
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      distributed_interrupt_line_out <= '0;
      distributed_interrupt_line_oe <= '0;
      pin_out <= '0;
      pin_oe <= DIR_PIN_DIR_RST;
      pin_term <= '0;
    end else begin
      for (int i = 0; i < DIR_LINES; i++) begin
        distributed_interrupt_line_out[i] <= pick(src_ff[i]);
        distributed_interrupt_line_oe[i] <= src_ff[i][6:4] != DIR_SK_NONE && src_ff[i][6:4] != DIR_SK_DI;
      end
      for (int i = 0; i < DIR_PINS; i++) begin
        pin_out[i] <= dir_ff[i] & pick(pin_src_ff[i]);
        pin_oe[i] <= dir_ff[i];
      end
      pin_term <= term_ff;
    end
  end

  for (genvar g = 0; g < DIR_LINES; g++) begin : g_line
    dir_line_detect u_det (
      .pclk(pclk),
      .presetn(presetn),
      .line_in(distributed_interrupt_line_in[g]),
      .trig_mode(trig_ff[2*g +: 2]),
      .armed(arm_ff[g]),
      .enabled(en_ff[g]),
      .sw_request(req_ff[g]),
      .fire(fire[g]),
      .fire_count(cnt[g])
    );
  end

  assign irq_fire = fire;

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_prdata = '0;
    if (paddr < DIR_OFF_SRC0 + 12'(4 * DIR_LINES)) nxt_prdata = {25'h0, src_ff[widx]};
    else if (paddr >= DIR_OFF_PIN_OUT0 && paddr < DIR_OFF_PIN_OUT0 + 12'(4 * DIR_PINS))
      nxt_prdata = {25'h0, pin_src_ff[4'(paddr[5:2] - DIR_OFF_PIN_OUT0[5:2])]};
    else if (paddr >= DIR_OFF_CNT0 && paddr < DIR_OFF_CNT0 + 12'(4 * DIR_LINES)) nxt_prdata = cnt[widx];
    else begin
      case (paddr)
        DIR_OFF_TRIG: nxt_prdata = {8'h0, trig_ff};
        DIR_OFF_ARM_SET: nxt_prdata = {20'h0, arm_ff};
        DIR_OFF_EN_SET: nxt_prdata = {20'h0, en_ff};
        DIR_OFF_KEEP: nxt_prdata = {20'h0, keep_ff};
        DIR_OFF_STATUS: nxt_prdata = {20'h0, status_ff};
        DIR_OFF_PIN_DIR: nxt_prdata = {20'h0, dir_ff};
        DIR_OFF_PIN_TERM: nxt_prdata = {20'h0, term_ff};
        DIR_OFF_CLKCFG: nxt_prdata = {24'h0, clkcfg_ff};
        DIR_OFF_ERROR: nxt_prdata = err_ff;
        DIR_OFF_PIG: nxt_prdata = {20'h0, pig_ff};
        default: nxt_prdata = '0;
      endcase
    end
  end

  // captured in the setup cycle, so zero wait states and still a flop on the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
    end else begin
      prdata_ff <= (psel && !penable && !pwrite) ? nxt_prdata : '0;
    end
  end

  assign prdata = rd ? prdata_ff : '0;

endmodule

// ---- tb/dir_peer.sv ----
// partner model: another chained board holding levels on the received lines
`timescale 1ns/100ps
module dir_peer
  import dir_pkg::*;
#(
  parameter int HOLD = 25
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [DIR_LINES-1:0] want,
  input wire logic [DIR_LINES-1:0] line_out,
  input wire logic [DIR_LINES-1:0] line_oe,
  output logic [DIR_LINES-1:0] line_in
);
  logic [DIR_LINES-1:0] lvl_ff;
  logic [5:0] age_ff [DIR_LINES];
  // a wanted change waits until the old level has stood its minimum time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_ff <= '0;
      age_ff <= '{default: '0};
    end else begin
      for (int i = 0; i < DIR_LINES; i++) begin
        if (want[i] != lvl_ff[i] && age_ff[i] >= 6'(HOLD)) begin
          lvl_ff[i] <= want[i];
          age_ff[i] <= '0;
        end else if (age_ff[i] != 6'h3f) begin
          age_ff[i] <= age_ff[i] + 6'h1;
        end
      end
    end
  end
  // chain wiring: what this board drives also comes back on its receive side
  assign line_in = lvl_ff | (line_out & line_oe);
endmodule

// ---- tb/dir_chk.sv ----
// checker: port-level properties of the distributed interrupt routing top
`timescale 1ns/100ps
module dir_chk
  import dir_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [DIR_LINES-1:0] distributed_interrupt_line_oe,
  input wire logic [DIR_PINS-1:0] pin_oe,
  input wire logic [DIR_PINS-1:0] pin_term,
  input wire logic [DIR_LINES-1:0] irq_fire,
  input wire logic time_master,
  input wire logic time_tick
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr, src_ff;
  logic [3:0] pidx;
  logic [11:0] arm_ff, en_ff, keep_ff, mask;
  assign wr = psel && penable && pready && pwrite;
  assign pidx = 4'((paddr - DIR_OFF_PIN_OUT0) >> 2);
  assign mask = pwdata[11:0] & arm_ff & en_ff;
  // shadow of arm, enable and keep, rebuilt from bus writes alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_ff <= '0;
      en_ff <= '0;
      keep_ff <= '0;
      src_ff <= 1'b0;
    end else if (wr) begin
      case (paddr)
        DIR_OFF_ARM_SET: arm_ff <= arm_ff | pwdata[11:0];
        DIR_OFF_ARM_CLR: arm_ff <= arm_ff & ~pwdata[11:0];
        DIR_OFF_RELEASE: arm_ff <= arm_ff & ~(pwdata[11:0] & ~keep_ff);
        DIR_OFF_EN_SET: en_ff <= en_ff | pwdata[11:0];
        DIR_OFF_EN_CLR: en_ff <= en_ff & ~pwdata[11:0];
        DIR_OFF_KEEP: keep_ff <= pwdata[11:0];
        default: src_ff <= src_ff | (paddr < DIR_OFF_TRIG);
      endcase
    end
  end
  no_drive_a: assert property (distributed_interrupt_line_oe != '0 |-> src_ff)
    else $error("line driven before any source write");
  pin_reset_a: assert property ($rose(presetn) |=> pin_oe == DIR_PIN_DIR_RST && pin_term == '0)
    else $error("pin setup after reset wrong");
  pin_dir_a: assert property (wr && paddr == DIR_OFF_PIN_DIR |=> ##1 pin_oe == $past(pwdata[11:0], 2))
    else $error("pin direction not applied");
  self_route_a: assert property (wr && paddr >= DIR_OFF_PIN_OUT0 && paddr < DIR_OFF_ERROR
    && pwdata[6:4] == DIR_SK_INPUT && pwdata[3:0] == pidx |-> pslverr) else $error("self route accepted");
  arm_gate_a: assert property (irq_fire != '0 |-> (irq_fire & ~(arm_ff & en_ff)) == '0)
    else $error("fire on unarmed or disabled line");
  sw_req_a: assert property (wr && paddr == DIR_OFF_REQUEST |=> (irq_fire & $past(mask)) == $past(mask))
    else $error("software request did not fire");
  master_dflt_a: assert property ($rose(presetn) |-> time_master)
    else $error("time master off after reset");
  slave_time_a: assert property (wr && paddr == DIR_OFF_CLKCFG && pwdata[DIR_CC_SLAVE] |=> !time_master)
    else $error("slave still time master");
  master_off_a: assert property (wr && paddr == DIR_OFF_CLKCFG && !pwdata[DIR_CC_MASTER] |=> !time_master)
    else $error("time master not turned off");
  tick_gap_a: assert property (time_tick |=> !time_tick)
    else $error("tick pulses back to back");
endmodule
bind dir_top dir_chk i_chk (.*);

// ---- tb/dir_top_test.sv ----
// testbench: scenarios for the distributed interrupt routing top
`timescale 1ns/100ps
module dir_top_test
  import dir_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic gps_pps = 1'b0, irig_pps = 1'b0;
  logic [11:0] paddr = '0, pin_in = '0, want = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [DIR_TIMERS-1:0] timer_pulse = '0;
  logic pready, pslverr, time_master, time_tick;
  logic [11:0] distributed_interrupt_line_in, distributed_interrupt_line_out, distributed_interrupt_line_oe;
  logic [11:0] pin_out, pin_oe, pin_term, irq_fire;
  wire [11:0] lo = distributed_interrupt_line_out;
  wire [11:0] loe = distributed_interrupt_line_oe;
  int n_errors = 0, num_checks = 0, nt = 0;
  int nf [12] = '{default: 0};
  always #20 pclk = ~pclk;
  // non-blocking, so a read at the same edge always sees the older total
  always @(posedge pclk) begin
    nt <= nt + int'(time_tick === 1'b1);
    for (int i = 0; i < 12; i++) nf[i] <= nf[i] + int'(irq_fire[i] === 1'b1);
  end
  dir_top i_dut (.*);
  dir_peer #(.HOLD(25)) i_peer (.pclk(pclk), .presetn(presetn), .want(want),
    .line_out(distributed_interrupt_line_out), .line_oe(distributed_interrupt_line_oe),
    .line_in(distributed_interrupt_line_in));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      $display("unexpected %s expected %h seen %h", n, x, s);
      n_errors++;
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(n, r, x);
  endtask
  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    tk(2);
    chk("pin_oe", 32'(pin_oe), 32'h3f);
    chk("pin_term", 32'(pin_term), 32'h0);
    chk("line_oe", 32'(loe), 32'h0);
    chk("master", 32'(time_master), 32'h1);
    for (int i = 0; i < 12; i++) rd(DIR_OFF_SRC0 + 12'(4 * i), 32'h0, "src");
    apb(1'b0, 12'h0b0, 32'h0, r, e);
    chk("unmapped_err", 32'(e), 32'h1);
    chk("unmapped_data", r, 32'h0);
  endtask
  task automatic t_pins;
    logic [31:0] r;
    logic e;
    wr(DIR_OFF_PIN_DIR, 32'hfc0);
    wr(DIR_OFF_PIN_TERM, 32'h0a5);
    tk(2);
    chk("pin_oe", 32'(pin_oe), 32'hfc0);
    chk("pin_term", 32'(pin_term), 32'h0a5);
    wr(DIR_OFF_PIN_DIR, 32'h3f);
    apb(1'b1, DIR_OFF_PIN_OUT0, {25'h0, DIR_SK_INPUT, 4'h0}, r, e);
    chk("self_route", 32'(e), 32'h1);
    rd(DIR_OFF_ERROR, DIR_ERR_INVAL, "error");
    rd(DIR_OFF_PIN_OUT0, 32'h0, "pin_src");
    wr(DIR_OFF_PIN_OUT0 + 12'h4, {25'h0, DIR_SK_PIG, 4'h2});
    for (int v = 1; v >= 0; v--) begin
      wr(v ? DIR_OFF_PIG_SET : DIR_OFF_PIG_CLR, 32'h4);
      tk(2);
      chk("pin_out", 32'(pin_out[1]), 32'(v));
    end
  endtask
  task automatic drv(input int k, input logic v);
    case (k)
      0: timer_pulse[3] <= v;
      1: wr(v ? DIR_OFF_PIG_SET : DIR_OFF_PIG_CLR, 32'h2);
      2: pin_in[8] <= v;
      3: gps_pps <= v;
      4: irig_pps <= v;
      default: pin_in[0] <= v;
    endcase
  endtask
  task automatic t_route;
    logic [6:0] sel [6] = '{7'h13, 7'h21, 7'h38, 7'h40, 7'h50, 7'h30};
    // gps pulses pass only with the gps bit set; master bit kept on
    wr(DIR_OFF_CLKCFG, 32'ha);
    for (int k = 0; k < 6; k++) begin
      wr(DIR_OFF_SRC0 + 12'(4 * (k + 4)), {25'h0, sel[k]});
      drv(k, 1'b1);
      tk(5);
      chk("line_out", 32'(lo[k + 4] & loe[k + 4]), 32'(k < 5));
      drv(k, 1'b0);
      tk(5);
      chk("line_out", 32'(lo[k + 4]), 32'h0);
      wr(DIR_OFF_SRC0 + 12'(4 * (k + 4)), 32'h0);
      tk(2);
      chk("line_oe", 32'(loe[k + 4]), 32'h0);
    end
  endtask
  task automatic t_trig;
    int b;
    wr(DIR_OFF_ARM_SET, 32'h4);
    wr(DIR_OFF_EN_SET, 32'h4);
    for (int m = 0; m < 5; m++) begin
      if (m == 4) wr(DIR_OFF_EN_CLR, 32'h4);
      else wr(DIR_OFF_TRIG, 32'(m) << 4);
      tk(40);
      b = nf[2];
      want[2] <= 1'b1;
      tk(40);
      want[2] <= 1'b0;
      tk(40);
      chk("fires", 32'(nf[2] - b), 32'(m < 4));
    end
    rd(DIR_OFF_CNT0 + 12'h8, 32'(nf[2]), "count");
  endtask
  task automatic t_req;
    int b;
    wr(DIR_OFF_ARM_SET, 32'h18);
    wr(DIR_OFF_EN_SET, 32'h18);
    wr(DIR_OFF_KEEP, 32'h8);
    b = nf[3];
    wr(DIR_OFF_REQUEST, 32'h8);
    tk(3);
    chk("sw_fire", 32'(nf[3] - b), 32'h1);
    rd(DIR_OFF_CNT0 + 12'hc, 32'(nf[3]), "count");
    wr(DIR_OFF_RELEASE, 32'h18);
    rd(DIR_OFF_ARM_SET, 32'hc, "armed");
    b = nf[4];
    wr(DIR_OFF_REQUEST, 32'h10);
    tk(3);
    chk("no_fire", 32'(nf[4] - b), 32'h0);
    rd(DIR_OFF_STATUS, 32'hc, "status");
    wr(DIR_OFF_STATUS, 32'hc);
    rd(DIR_OFF_STATUS, 32'h0, "status");
  endtask
  task automatic t_clock;
    int b;
    logic [31:0] cfg [3] = '{32'h6, 32'h2, 32'h0};
    b = nt;
    tk(250);
    chk("ticks", 32'(nt - b), 32'd100);
    // reference on input pin 7; held still, no tick may come from the crystal
    wr(DIR_OFF_CLKCFG, 32'h73);
    tk(10);
    b = nt;
    tk(100);
    chk("ticks_ext", 32'(nt - b), 32'h0);
    for (int i = 0; i < 50; i++) begin
      pin_in[7] <= 1'b1;
      tk(2);
      pin_in[7] <= 1'b0;
      tk(3);
    end
    tk(10);
    chk("ticks_ext", 32'(nt - b), 32'd50);
    for (int i = 0; i < 3; i++) begin
      wr(DIR_OFF_CLKCFG, cfg[i]);
      tk(1);
      chk("master", 32'(time_master), 32'(i == 1));
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    tk(4);
    presetn <= 1'b1;
    t_reset;
    t_pins;
    t_route;
    t_trig;
    t_req;
    t_clock;
    report_and_stop;
  end
  initial begin
    tk(20000);
    n_errors++;
    report_and_stop;
  end
endmodule
